// file: hw/epst_map.vh
// Command codes, status byte layout and reset values of the endpoint status block.
// Assumes inclusion by the block's design files only.
// Notes on behaviour
// R1: Codes 50h-5Fh read one endpoint status byte.
// R2: Status read clears that endpoint's interrupt bit.
// R3: Status byte read-only; bit 0 reserved.
// R4: Bit 7 halt; stall sets, unstall clears.
// R5: Bit 6 second full; bit 5 first full.
// R6: Bit 4 gives next data toggle.
// R7: Bit 3 set on unacknowledged set-up setup_overrun_flag.
// R8: Status read clears setup_overrun_flag after set-up written.
// R9: Processor checks setup_overrun_flag before acknowledge or stall.
// R10: Bit 2 set while buffer holds set-up.
// R11: Bit 1 shows processor buffer select.
// R12: Set-up token unstalls stalled control endpoint.
// R13: Processor may re-stall after set-up unstall.
// R14: Any unstall flushes buffer, toggle to DATA0.
// R15: Codes 40h-4Fh stall, no data phase.
// R16: Codes 80h-8Fh unstall, no data phase.
// R17: Validate sets full flag of IN endpoint.
// R18: Validate toggles buffer select when double-buffered.
// R19: Codes 61h-6Fh validate; no data phase.
// R20: Low nibble selects endpoint index.
// R21: Status bits read zero after reset.
`ifndef EPST_MAP_VH
`define EPST_MAP_VH
`define EPST_NUM_EP 16
`define EPST_CMD_GRP_READ 4'h5
`define EPST_CMD_GRP_STALL 4'h4
`define EPST_CMD_GRP_UNSTALL 4'h8
`define EPST_CMD_GRP_VALID 4'h6
`define EPST_EP_CTRL_OUT 4'h0
`define EPST_EP_CTRL_IN 4'h1
`define EPST_BIT_HALT 7
`define EPST_BIT_FULL1 6
`define EPST_BIT_FULL0 5
`define EPST_BIT_TOGGLE 4
`define EPST_BIT_OVERRUN 3
`define EPST_BIT_SETUP 2
`define EPST_BIT_CPU_BUFFER_SELECT 1
`define EPST_BIT_RSVD 0
`define EPST_STATUS_RESET 8'h00
`define EPST_INT_RESET 16'h0000
`endif

// file: hw/epst_ep_state.v
// One endpoint's status flags, updated from decoded command and USB event strobes.
// Assumes strobes are one-cycle pulses synchronous to clock.
`timescale 1ns/1ps
`include "epst_map.vh"
module epst_ep_state (
	input wire clock,
	input wire rst_n,
	input wire stall_cmd,
	input wire unstall_cmd,
	input wire validate_cmd,
	input wire status_read,
	input wire is_control,
	input wire is_in,
	input wire double_buf,
	input wire setup_token,
	input wire setup_done,
	input wire setup_ack,
	input wire toggle_flip,
	input wire buf_tx_done,
	input wire buf_rx_done,
	input wire buf_clear,
	output wire [7:0] status
);
	reg halt_q;
	reg full0_q;
	reg full1_q;
	reg toggle_q;
	reg overrun_q;
	reg setup_q;
	reg cpu_buffer_select_q;
	reg setup_busy_q;
	wire unstall_any;
	wire flush_any;
	// Set-up token only unstalls a halted control endpoint
	assign unstall_any = unstall_cmd | (setup_token & is_control & halt_q); // R12
	assign flush_any = unstall_cmd | (setup_token & is_control); // R14

	////////////////////////////////////////////////////////////////////////
	// Flag registers; hardware sets win over the status-read clear
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			halt_q <= 1'b0; // R21
			full0_q <= 1'b0;
			full1_q <= 1'b0;
			toggle_q <= 1'b0;
			overrun_q <= 1'b0;
			setup_q <= 1'b0;
			cpu_buffer_select_q <= 1'b0;
			setup_busy_q <= 1'b0;
		end else begin
			// Halt: stall wins if both arrive, keeps re-stall possible
			if (stall_cmd)
				halt_q <= 1'b1; // R4
			else if (unstall_any)
				halt_q <= 1'b0; // R4
			// Any unstall reinitialises: empty buffers, DATA0 next
			if (unstall_any) begin
				full0_q <= 1'b0; // R14
				full1_q <= 1'b0;
				toggle_q <= 1'b0; // R14
				cpu_buffer_select_q <= 1'b0;
			end else begin
				if (validate_cmd & is_in) begin
					// Validate marks the processor's buffer full
					if (cpu_buffer_select_q)
						full1_q <= 1'b1; // R17
					else
						full0_q <= 1'b1; // R17
					if (double_buf)
						cpu_buffer_select_q <= ~cpu_buffer_select_q; // R18
				end else if (buf_rx_done) begin
					if (cpu_buffer_select_q)
						full1_q <= 1'b1; // R5
					else
						full0_q <= 1'b1; // R5
				end else if (buf_tx_done | buf_clear) begin
					if (cpu_buffer_select_q)
						full1_q <= 1'b0; // R5
					else
						full0_q <= 1'b0; // R5
					if (buf_clear & double_buf)
						cpu_buffer_select_q <= ~cpu_buffer_select_q; // R11
				end
				if (toggle_flip)
					toggle_q <= ~toggle_q; // R6
			end
			// Set-up packet present until acknowledged
			if (setup_token & is_control)
				setup_q <= 1'b1; // R10
			else if (setup_ack)
				setup_q <= 1'b0;
			// Setup_overrun_flag of pending set-up, cleared by read once written
			if (setup_token & is_control)
				setup_busy_q <= 1'b1;
			else if (setup_done)
				setup_busy_q <= 1'b0;
			if (setup_token & is_control & setup_q & ~halt_q)
				overrun_q <= 1'b1; // R7
			else if (status_read & ~setup_busy_q)
				overrun_q <= 1'b0; // R8
		end
	end

	// Reserved bit 0 reads zero
	assign status = {halt_q, full1_q, full0_q, toggle_q, overrun_q, setup_q, cpu_buffer_select_q, 1'b0}; // R3
endmodule // epst_ep_state

// file: hw/epst_endpoint_ctrl.v
// Endpoint status, stall, unstall and validate command handling.
// Assumes one-byte commands strobed by the processor port and USB event
// strobes from the serial engine, all synchronous to clock.
`timescale 1ns/1ps
`include "epst_map.vh"
module epst_endpoint_ctrl (
	input wire clock,
	input wire rst_n,
	input wire cmd_valid,
	input wire [7:0] cmd_code,
	input wire data_read,
	input wire [15:0] ep_is_in,
	input wire [15:0] ep_double_buf,
	input wire [15:0] setup_token,
	input wire [15:0] setup_done,
	input wire [15:0] setup_ack,
	input wire [15:0] toggle_flip,
	input wire [15:0] buf_tx_done,
	input wire [15:0] buf_rx_done,
	input wire [15:0] buf_clear,
	input wire [15:0] int_set,
	output reg [7:0] read_data,
	output reg read_valid,
	output reg [15:0] interrupt_status_word,
	output reg [15:0] endpoint_halted_flag
);
	localparam ST_IDLE = 2'b01;
	localparam ST_READ = 2'b10;
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [3:0] sel_q;
	wire [3:0] grp;
	wire [3:0] ep;
	wire [15:0] ep_hot;
	wire [7:0] status_all [0:15];
	reg [15:0] read_hot;
	wire [3:0] ep_sel_now;

	////////////////////////////////////////////////////////////////////////
	// Command decode: high nibble is group, low nibble endpoint
	assign grp = cmd_code[7:4];
	assign ep = cmd_code[3:0]; // R20
	assign ep_hot = 16'h0001 << ep;
	assign ep_sel_now = sel_q;

	// Status read strobe fires when the single data byte is taken
	always @* begin
		read_hot = 16'h0000;
		if (state_q == ST_READ && data_read)
			read_hot = 16'h0001 << sel_q; // R1
	end

	////////////////////////////////////////////////////////////////////////
	// One state block per endpoint
	genvar i;
	generate
		for (i = 0; i < `EPST_NUM_EP; i = i + 1) begin : g_ep
			epst_ep_state u_ep (
				.clock(clock),
				.rst_n(rst_n),
				.stall_cmd(cmd_valid && grp == `EPST_CMD_GRP_STALL && ep_hot[i]), // R15
				.unstall_cmd(cmd_valid && grp == `EPST_CMD_GRP_UNSTALL && ep_hot[i]), // R16
				// Validate undefined for control OUT (code 60h)
				.validate_cmd(cmd_valid && grp == `EPST_CMD_GRP_VALID && ep_hot[i]
					&& ep != `EPST_EP_CTRL_OUT), // R19
				.status_read(read_hot[i]),
				.is_control(i <= `EPST_EP_CTRL_IN),
				.is_in(ep_is_in[i] | (i == `EPST_EP_CTRL_IN)),
				.double_buf(ep_double_buf[i]),
				.setup_token(setup_token[i]),
				.setup_done(setup_done[i]),
				.setup_ack(setup_ack[i]),
				.toggle_flip(toggle_flip[i]),
				.buf_tx_done(buf_tx_done[i]),
				.buf_rx_done(buf_rx_done[i]),
				.buf_clear(buf_clear[i]),
				.status(status_all[i])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Read sequencer: code selects endpoint, then one byte is returned
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (cmd_valid && grp == `EPST_CMD_GRP_READ)
					state_d = ST_READ; // R1
			end
			ST_READ: begin
				// A new read restarts the answer; any other command drops it
				if (cmd_valid && grp == `EPST_CMD_GRP_READ)
					state_d = ST_READ; // R1
				else if (data_read || cmd_valid)
					state_d = ST_IDLE;
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			sel_q <= 4'h0;
		end else begin
			state_q <= state_d;
			if (cmd_valid)
				sel_q <= ep; // R20
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered outputs; status byte presented while a read is pending
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			read_data <= `EPST_STATUS_RESET; // R21
			read_valid <= 1'b0;
		end else begin
			read_valid <= (state_d == ST_READ);
			if (state_d == ST_READ)
				read_data <= status_all[cmd_valid ? ep : ep_sel_now]; // R3
			else
				read_data <= `EPST_STATUS_RESET;
		end
	end

	// Interrupt bits: new event wins over the read clear
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			interrupt_status_word <= `EPST_INT_RESET;
		else
			interrupt_status_word <= int_set | (interrupt_status_word & ~read_hot); // R2
	end

	// Halt flags mirrored for the serial engine's handshake choice
	integer k;
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			endpoint_halted_flag <= 16'h0000;
		else
			for (k = 0; k < `EPST_NUM_EP; k = k + 1)
				endpoint_halted_flag[k] <= status_all[k][`EPST_BIT_HALT]; // R4
	end
endmodule // epst_endpoint_ctrl

// file: testbench/epst_asserts.sv
// Checker for the endpoint command port.
// Assumes a bind to the top design module.
`timescale 1ns/1ps
module epst_asserts (
	input wire clock,
	input wire rst_n,
	input wire cmd_valid,
	input wire [7:0] cmd_code,
	input wire data_read,
	input wire [15:0] int_set,
	input wire [7:0] read_data,
	input wire read_valid,
	input wire [15:0] interrupt_status_word,
	input wire [15:0] endpoint_halted_flag
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Decoded groups; control endpoints skipped, set-up tokens unstall them
	wire rd_c = cmd_valid && cmd_code[7:4] == 4'h5;
	wire hi_ep = cmd_code[3:1] != 3'h0;
	////////////////////////////////
	a_read_answer: assert property (rd_c |=> read_valid)
		else $error("no read answer");
	a_read_drop: assert property (read_valid && data_read && !cmd_valid |=> !read_valid)
		else $error("read stays pending");
	a_rsvd_bit: assert property (read_valid |-> !read_data[0])
		else $error("reserved bit set");
	a_idle_data: assert property (!read_valid |-> read_data == 8'h00)
		else $error("data without read");
	a_stall_flag: assert property (cmd_valid && cmd_code[7:4] == 4'h4 && hi_ep
		|-> ##2 endpoint_halted_flag[$past(cmd_code[3:0], 2)]) else $error("stall lost");
	a_unstall_flag: assert property (cmd_valid && cmd_code[7:4] == 4'h8 && hi_ep
		|-> ##2 !endpoint_halted_flag[$past(cmd_code[3:0], 2)]) else $error("unstall lost");
	a_int_clear: assert property (rd_c ##1 (data_read && int_set == 16'h0000)
		|=> !interrupt_status_word[$past(cmd_code[3:0], 2)]) else $error("int kept");
	a_int_sticky: assert property (int_set != 16'h0000
		|=> (interrupt_status_word & $past(int_set)) == $past(int_set)) else $error("int lost");
	// Main scenarios reached
	c_read: cover property (rd_c ##1 data_read);
	c_stall: cover property (cmd_valid && cmd_code[7:4] == 4'h4);
	c_int: cover property (int_set != 16'h0000);
endmodule // epst_asserts

// file: testbench/epst_usb_host.sv
// USB-side event source: per-endpoint one-cycle strobes.
// Assumes the bench calls pulse one event at a time.
`timescale 1ns/1ps
module epst_usb_host (
	input wire clock,
	output logic [7:0][15:0] ev
);
	// Packed so that simple simulators accept the port
	initial ev = '0;
	// Token arrives whatever the packet holds
	task pulse(input int k, input int e);
		@(posedge clock);
		ev[k][e] <= 1'b1;
		@(posedge clock);
		ev[k] <= 16'h0000;
	endtask
endmodule // epst_usb_host

// file: testbench/tb_usb_endpoint_status_stall_validate.sv
// Bench for the endpoint status, stall and validate block.
// Assumes the checker and USB event model compile first.
`timescale 1ns/1ps
module tb_usb_endpoint_status_stall_validate;
	logic clock = 0, rst_n = 0, cmd_valid = 0, data_read = 0, read_valid;
	logic [7:0] cmd_code = 8'h00, read_data, st;
	logic [15:0] ep_is_in = 16'hFFFE, ep_dbl = 16'h0008, isw, halt;
	logic [7:0][15:0] ev;
	int n_errors = 0, num_checks = 0;
	epst_usb_host host (.clock(clock), .ev(ev));
	epst_endpoint_ctrl DUT (.clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .data_read(data_read), .ep_is_in(ep_is_in),
		.ep_double_buf(ep_dbl), .setup_token(ev[0]), .setup_done(ev[1]),
		.setup_ack(ev[2]), .toggle_flip(ev[3]), .buf_tx_done(ev[4]), .buf_rx_done(ev[5]),
		.buf_clear(ev[6]), .int_set(ev[7]), .read_data(read_data), .read_valid(read_valid),
		.interrupt_status_word(isw), .endpoint_halted_flag(halt));
	////////////////////////////////
	task chk(input string nm, input logic [15:0] exp, got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h got %h", nm, exp, got);
		end
	endtask
	task cmd(input logic [7:0] c);
		@(posedge clock);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		@(posedge clock);
		cmd_valid <= 1'b0;
	endtask
	// Byte is sampled after the answer edge settles
	task rd(input int e);
		cmd(8'h50 | e[7:0]);
		data_read <= 1'b1;
		#1 st = read_data;
		chk("read_valid", 1, read_valid);
		@(posedge clock);
		data_read <= 1'b0;
	endtask
	task t_reset;
		for (int e = 0; e < 16; e++) begin
			rd(e);
			chk("status", 8'h00, st);
		end
	endtask
	task t_stall;
		host.pulse(3, 9);
		rd(9);
		chk("toggle", 1, st[4]);
		for (int e = 0; e < 16; e++) cmd(8'h40 | e[7:0]);
		rd(9);
		chk("halt_bit", 1, st[7]);
		chk("halted", 16'hFFFF, halt);
		for (int e = 0; e < 16; e++) cmd(8'h80 | e[7:0]);
		rd(9);
		chk("flushed", 8'h00, st);
	endtask
	task t_setup;
		cmd(8'h40);
		host.pulse(0, 0);
		host.pulse(1, 0);
		rd(0);
		chk("auto_unstall", 0, st[7]);
		chk("setup_held", 1, st[2]);
		chk("overrun_pre", 0, st[3]);
		cmd(8'h40);
		host.pulse(0, 0);
		host.pulse(1, 0);
		host.pulse(0, 0);
		host.pulse(1, 0);
		rd(0);
		chk("overrun", 1, st[3]);
		rd(0);
		chk("overrun_clr", 0, st[3]);
	endtask
	// Set-up acknowledged first, though validate of control IN is not gated by the set-up bit
	task t_valid;
		host.pulse(2, 0);
		host.pulse(2, 1);
		cmd(8'h60);
		rd(0);
		chk("ignored", 2'b00, st[6:5]);
		for (int e = 1; e < 16; e++) begin
			cmd(8'h60 | e[7:0]);
			rd(e);
			chk("full", 1, st[5]);
		end
		rd(3);
		chk("cpu_buf", 1, st[1]);
	endtask
	task t_int;
		host.pulse(7, 5);
		#1 chk("int_set", 1, isw[5]);
		rd(5);
		#1 chk("int_clear", 0, isw[5]);
	endtask
	task results;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial forever #5 clock = ~clock;
	initial begin
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		t_reset;
		t_stall;
		t_setup;
		t_valid;
		t_int;
		results;
	end
	// Watchdog well past the few hundred cycles needed
	initial begin
		repeat (5000) @(posedge clock);
		n_errors++;
		results;
	end
endmodule // tb_usb_endpoint_status_stall_validate
bind epst_endpoint_ctrl epst_asserts chk_i (.clock(clock), .rst_n(rst_n),
	.cmd_valid(cmd_valid), .cmd_code(cmd_code), .data_read(data_read), .int_set(int_set),
	.read_data(read_data), .read_valid(read_valid),
	.interrupt_status_word(interrupt_status_word), .endpoint_halted_flag(endpoint_halted_flag));
